// ### fsc_status_reg.sv
`timescale 1ns/10ps
module fsc_status_reg #(
   parameter int ADD_DEPTH = fsc_pkg::ADD_DEPTH,
   parameter int MUL_DEPTH = fsc_pkg::MUL_DEPTH
) (
   // clock and reset
   input  wire logic                      core_clk,
   input  wire logic                      nrst,
   // control store and read
   input  wire logic                      ctl_store_en,
   input  wire logic [fsc_pkg::WORD_W-1:0] ctl_store_data,
   output logic      [fsc_pkg::WORD_W-1:0] status_word,
   // adder pipeline
   input  wire logic                      add_advance,
   input  wire logic                      add_round_up,
   input  wire logic                      add_inexact,
   input  wire logic                      add_overflow,
   input  wire logic                      add_underflow,
   input  wire logic [fsc_pkg::EXP_W-1:0]  add_exp,
   input  wire logic                      add_report,
   input  wire logic                      add_scalar,
   input  wire logic [fsc_pkg::RR_W-1:0]   add_dest_idx,
   // multiplier pipeline
   input  wire logic                      mul_advance,
   input  wire logic                      mul_round_up,
   input  wire logic                      mul_inexact,
   input  wire logic                      mul_overflow,
   input  wire logic                      mul_underflow,
   input  wire logic                      mul_report,
   input  wire logic                      mul_scalar,
   input  wire logic [fsc_pkg::RR_W-1:0]   mul_dest_idx,
   // last-stage precision of each pipe
   input  wire logic [1:0]                load_size,
   input  wire logic                      gfx_double,
   input  wire logic                      mul_double,
   input  wire logic                      add_double,
   // source operand check
   input  wire logic                      src_check,
   input  wire logic                      src_invalid,
   // controls to the units
   output fsc_pkg::fsc_round_t            round_mode,
   output logic                           flush_zero,
   // trap requests
   output logic                           result_trap,
   output logic                           source_trap
);

   // control fields
   logic                       fz_r;
   logic                       ti_r;
   logic [1:0]                 rm_r;
   logic                       fte_r;
   logic                       si_r;
   logic                       se_r;
   logic [fsc_pkg::RR_W-1:0]   rr_r;
   logic [fsc_pkg::RR_W-1:0]   rr_nxt;
   // precision fields
   logic [1:0]                 lsz_r;
   logic                       irp_r;
   logic                       mrp_r;
   logic                       arp_r;
   // trap outputs
   logic                       result_trap_r;
   logic                       source_trap_r;
   // pipe status
   logic [fsc_pkg::ADD_ST_W-1:0] add_in;
   logic [fsc_pkg::ADD_ST_W-1:0] add_ld;
   logic [fsc_pkg::ADD_ST_W-1:0] add_last;
   logic [fsc_pkg::MUL_ST_W-1:0] mul_in;
   logic [fsc_pkg::MUL_ST_W-1:0] mul_ld;
   logic [fsc_pkg::MUL_ST_W-1:0] mul_last;
   logic                       upd_load;
   logic                       add_exc;
   logic                       mul_exc;
   logic                       trap_nxt;

   // restore only with the update bit in the stored value
   assign upd_load = ctl_store_en
                   & ctl_store_data[fsc_pkg::UPD_BIT];

   // adder status: round-up, inexact, overflow, underflow, exponent
   assign add_in = {add_round_up, add_inexact, add_overflow,
                    add_underflow,
                    add_exp[fsc_pkg::EXP_W-1 -: fsc_pkg::AE_W]};
   assign add_ld = {ctl_store_data[fsc_pkg::AA_BIT],
                    ctl_store_data[fsc_pkg::AI_BIT],
                    ctl_store_data[fsc_pkg::AO_BIT],
                    ctl_store_data[fsc_pkg::AU_BIT],
                    ctl_store_data[fsc_pkg::AE_HI:fsc_pkg::AE_LO]};
   // multiplier status: round-up, inexact, overflow, underflow
   assign mul_in = {mul_round_up, mul_inexact, mul_overflow,
                    mul_underflow};
   assign mul_ld = {ctl_store_data[fsc_pkg::MA_BIT],
                    ctl_store_data[fsc_pkg::MI_BIT],
                    ctl_store_data[fsc_pkg::MO_BIT],
                    ctl_store_data[fsc_pkg::MU_BIT]};

   fsc_stat_pipe #(
      .WIDTH (fsc_pkg::ADD_ST_W),
      .DEPTH (ADD_DEPTH)
   ) u_add_pipe (
      .core_clk    (core_clk),
      .nrst        (nrst),
      .advance     (add_advance),
      .in_status   (add_in),
      .load_en     (upd_load),
      .load_status (add_ld),
      .last_status (add_last)
   );

   fsc_stat_pipe #(
      .WIDTH (fsc_pkg::MUL_ST_W),
      .DEPTH (MUL_DEPTH)
   ) u_mul_pipe (
      .core_clk    (core_clk),
      .nrst        (nrst),
      .advance     (mul_advance),
      .in_status   (mul_in),
      .load_en     (upd_load),
      .load_status (mul_ld),
      .last_status (mul_last)
   );

   // control bits written directly by every store
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         fz_r  <= 1'b0;
         ti_r  <= 1'b0;
         rm_r  <= 2'h0;
         fte_r <= 1'b0;
      end else if (ctl_store_en) begin
         fz_r  <= ctl_store_data[fsc_pkg::FZ_BIT];
         ti_r  <= ctl_store_data[fsc_pkg::TI_BIT];
         rm_r  <= ctl_store_data[fsc_pkg::RM_HI:fsc_pkg::RM_LO];
         fte_r <= ctl_store_data[fsc_pkg::FTE_BIT];
      end
   end

   // sticky inexact: a last-stage inexact beats a clearing store
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         si_r <= 1'b0;
      end else begin
         si_r <= (ctl_store_en ? ctl_store_data[fsc_pkg::SI_BIT] : si_r)
               | add_last[fsc_pkg::AE_W+2]
               | mul_last[2];
      end
   end

   // operand check overrides a store in the same cycle
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         se_r <= 1'b0;
      end else if (src_check) begin
         se_r <= src_invalid;
      end else if (ctl_store_en) begin
         se_r <= ctl_store_data[fsc_pkg::SE_BIT];
      end
   end

   // exceptions visible on the last stage at report time
   assign add_exc = add_report
                  & (add_last[fsc_pkg::AE_W+1]
                     | (add_last[fsc_pkg::AE_W] & ~fz_r)
                     | (add_last[fsc_pkg::AE_W+2] & ti_r));
   assign mul_exc = mul_report
                  & (mul_last[1]
                     | (mul_last[0] & ~fz_r)
                     | (mul_last[2] & ti_r));
   assign trap_nxt = fte_r & (add_exc | mul_exc);

   // destination index: a scalar trap beats a store
   always_comb begin
      rr_nxt = rr_r;
      if (ctl_store_en) begin
         rr_nxt = ctl_store_data[fsc_pkg::RR_HI:fsc_pkg::RR_LO];
      end
      if (trap_nxt && add_exc && add_scalar) begin
         rr_nxt = add_dest_idx;
      end else if (trap_nxt && mul_exc && mul_scalar) begin
         rr_nxt = mul_dest_idx;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rr_r <= fsc_pkg::RR_RST;
      end else begin
         rr_r <= rr_nxt;
      end
   end

   // trap requests, one-cycle pulses
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         result_trap_r <= 1'b0;
         source_trap_r <= 1'b0;
      end else begin
         result_trap_r <= trap_nxt;
         source_trap_r <= fte_r & src_check & src_invalid;
      end
   end

   // precision follows the pipes only
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         lsz_r <= fsc_pkg::LSZ_RST;
         irp_r <= 1'b0;
         mrp_r <= 1'b0;
         arp_r <= 1'b0;
      end else begin
         lsz_r <= load_size;
         irp_r <= gfx_double;
         mrp_r <= mul_double;
         arp_r <= add_double;
      end
   end

   // read view, update bit and reserved bits read zero
   always_comb begin
      status_word = '0;
      status_word[fsc_pkg::FZ_BIT]  = fz_r;
      status_word[fsc_pkg::TI_BIT]  = ti_r;
      status_word[fsc_pkg::RM_HI:fsc_pkg::RM_LO] = rm_r;
      status_word[fsc_pkg::FTE_BIT] = fte_r;
      status_word[fsc_pkg::SI_BIT]  = si_r;
      status_word[fsc_pkg::SE_BIT]  = se_r;
      status_word[fsc_pkg::MU_BIT]  = mul_last[0];
      status_word[fsc_pkg::MO_BIT]  = mul_last[1];
      status_word[fsc_pkg::MI_BIT]  = mul_last[2];
      status_word[fsc_pkg::MA_BIT]  = mul_last[3];
      status_word[fsc_pkg::AE_HI:fsc_pkg::AE_LO] =
         add_last[fsc_pkg::AE_W-1:0];
      status_word[fsc_pkg::AU_BIT]  = add_last[fsc_pkg::AE_W];
      status_word[fsc_pkg::AO_BIT]  = add_last[fsc_pkg::AE_W+1];
      status_word[fsc_pkg::AI_BIT]  = add_last[fsc_pkg::AE_W+2];
      status_word[fsc_pkg::AA_BIT]  = add_last[fsc_pkg::AE_W+3];
      status_word[fsc_pkg::RR_HI:fsc_pkg::RR_LO] = rr_r;
      status_word[fsc_pkg::LSZ_LO_BIT] = lsz_r[0];
      status_word[fsc_pkg::LSZ_HI_BIT] = lsz_r[1];
      status_word[fsc_pkg::IRP_BIT] = irp_r;
      status_word[fsc_pkg::MRP_BIT] = mrp_r;
      status_word[fsc_pkg::ARP_BIT] = arp_r;
   end

   assign round_mode  = fsc_pkg::fsc_round_t'(rm_r);
   assign flush_zero  = fz_r;
   assign result_trap = result_trap_r;
   assign source_trap = source_trap_r;

   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   sequence s_store_upd;
      ctl_store_en && ctl_store_data[fsc_pkg::UPD_BIT];
   endsequence

   sequence s_two_adv;
      (!add_advance && !upd_load) ##1 (add_advance && !upd_load)
      ##1 (!add_advance && !upd_load) ##1 (add_advance && !upd_load);
   endsequence

   update_zero_a: assert property (
      status_word[fsc_pkg::UPD_BIT] == 1'b0)
      else $error("update bit read back as one");

   no_trap_off_a: assert property (
      !fte_r |=> !result_trap && !source_trap)
      else $error("trap raised with master enable clear");

   sticky_hold_a: assert property (
      si_r && !ctl_store_en |=> si_r)
      else $error("sticky inexact dropped without a store");

   sticky_set_a: assert property (
      add_last[fsc_pkg::AE_W+2] || mul_last[2] |=> si_r)
      else $error("sticky inexact missed last-stage inexact");

   sticky_clear_a: assert property (
      ctl_store_en && !ctl_store_data[fsc_pkg::SI_BIT]
      && !add_last[fsc_pkg::AE_W+2] && !mul_last[2] |=> !si_r)
      else $error("sticky inexact not cleared by store");

   round_follow_a: assert property (
      ctl_store_en
      |=> round_mode == $past(ctl_store_data[fsc_pkg::RM_HI:fsc_pkg::RM_LO]))
      else $error("round mode does not follow the store");

   source_trap_a: assert property (
      fte_r && src_check && src_invalid |=> source_trap)
      else $error("invalid operand raised no trap");

   load_size_a: assert property (
      ctl_store_en |=> {status_word[fsc_pkg::LSZ_HI_BIT],
                        status_word[fsc_pkg::LSZ_LO_BIT]} == $past(load_size))
      else $error("load size taken from a store");

   uflow_flush_a: assert property (
      add_report && fz_r && fte_r && add_last[fsc_pkg::AE_W]
      && !add_last[fsc_pkg::AE_W+1] && !add_last[fsc_pkg::AE_W+2]
      && !mul_report |=> !result_trap)
      else $error("underflow trapped while flushing to zero");

   uflow_trap_a: assert property (
      add_report && !fz_r && fte_r && add_last[fsc_pkg::AE_W]
      |=> result_trap)
      else $error("underflow without trap");

   inexact_gate_a: assert property (
      fte_r && !ti_r
      && ((mul_report && mul_last[2] && !mul_last[1] && !mul_last[0]
           && !add_report)
          || (add_report && add_last[fsc_pkg::AE_W+2]
              && !add_last[fsc_pkg::AE_W+1] && !add_last[fsc_pkg::AE_W]
              && !mul_report))
      |=> !result_trap)
      else $error("inexact trapped with trap enable clear");

   restore_path_a: assert property (
      s_store_upd ##1 s_two_adv
      |=> status_word[fsc_pkg::AI_BIT]
          == $past(ctl_store_data[fsc_pkg::AI_BIT], 5))
      else $error("restored adder status lost on the way out");

   direct_write_a: assert property (
      ctl_store_en && !src_check && !trap_nxt |=>
      (status_word[fsc_pkg::SE_BIT:fsc_pkg::FZ_BIT] & 9'h12F)
         == ($past(ctl_store_data[fsc_pkg::SE_BIT:fsc_pkg::FZ_BIT]) & 9'h12F)
      && rr_r == $past(ctl_store_data[fsc_pkg::RR_HI:fsc_pkg::RR_LO])
      && (status_word[fsc_pkg::SI_BIT]
          || !$past(ctl_store_data[fsc_pkg::SI_BIT])))
      else $error("store did not write control bits");

   operand_flag_a: assert property (
      src_check |=> se_r == $past(src_invalid))
      else $error("operand flag does not match the check");

   dest_index_a: assert property (
      trap_nxt && add_exc && add_scalar
      |=> rr_r == $past(add_dest_idx) && result_trap)
      else $error("destination index not recorded");

   precision_a: assert property (
      ctl_store_en |=> status_word[fsc_pkg::ARP_BIT] == $past(add_double))
      else $error("adder precision taken from a store");

endmodule // fsc_status_reg

// ### fsc_pkg.sv
package fsc_pkg;

   // control bits, written by stores; the update bit is not kept
   localparam int FZ_BIT      = 0;
   localparam int TI_BIT      = 1;
   localparam int RM_LO       = 2;
   localparam int RM_HI       = 3;
   localparam int UPD_BIT     = 4;
   localparam int FTE_BIT     = 5;
   localparam int SI_BIT      = 7;
   localparam int SE_BIT      = 8;
   // multiplier result status
   localparam int MU_BIT      = 9;
   localparam int MO_BIT      = 10;
   localparam int MI_BIT      = 11;
   localparam int MA_BIT      = 12;
   // adder result status
   localparam int AU_BIT      = 13;
   localparam int AO_BIT      = 14;
   localparam int AI_BIT      = 15;
   localparam int AA_BIT      = 16;
   // destination index and exponent
   localparam int RR_LO       = 17;
   localparam int RR_HI       = 21;
   localparam int AE_LO       = 22;
   localparam int AE_HI       = 24;
   // precision indicators
   localparam int LSZ_LO_BIT  = 25;
   localparam int IRP_BIT     = 26;
   localparam int MRP_BIT     = 27;
   localparam int ARP_BIT     = 28;
   localparam int LSZ_HI_BIT  = 29;

   // widths
   localparam int WORD_W      = 32;
   localparam int RR_W        = 5;
   localparam int AE_W        = 3;
   localparam int EXP_W       = 11;
   localparam int ADD_ST_W    = 4 + AE_W;
   localparam int MUL_ST_W    = 4;
   localparam int ADD_DEPTH   = 3;
   localparam int MUL_DEPTH   = 3;

   // reset values
   localparam logic [RR_W-1:0] RR_RST  = 5'h00;
   localparam logic [1:0]      LSZ_RST = 2'h0;

   // load size codes
   localparam logic [1:0] LSZ_RSVD = 2'h0;
   localparam logic [1:0] LSZ_4B   = 2'h1;
   localparam logic [1:0] LSZ_8B   = 2'h2;
   localparam logic [1:0] LSZ_16B  = 2'h3;

   typedef enum logic [1:0] {
      FSC_RM_NEAREST = 2'h0,
      FSC_RM_DOWN    = 2'h1,
      FSC_RM_UP      = 2'h2,
      FSC_RM_CHOP    = 2'h3
   } fsc_round_t;

endpackage

// ### fsc_stat_pipe.sv
`timescale 1ns/10ps
module fsc_stat_pipe #(
   parameter int WIDTH = 4,
   parameter int DEPTH = 3
) (
   // clock and reset
   input  wire logic             core_clk,
   input  wire logic             nrst,
   // operation advance
   input  wire logic             advance,
   input  wire logic [WIDTH-1:0] in_status,
   // restore into first stage
   input  wire logic             load_en,
   input  wire logic [WIDTH-1:0] load_status,
   // last stage
   output logic      [WIDTH-1:0] last_status
);

   logic [WIDTH-1:0] stage_r [DEPTH];

   // first stage: restore wins over a new operation
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         stage_r[0] <= '0;
      end else if (load_en) begin
         stage_r[0] <= load_status;
      end else if (advance) begin
         stage_r[0] <= in_status;
      end
   end

   // later stages move one step per operation
   genvar gi;
   generate
      for (gi = 1; gi < DEPTH; gi++) begin : g_stage
         always_ff @(posedge core_clk or negedge nrst) begin
            if (!nrst) begin
               stage_r[gi] <= '0;
            end else if (advance) begin
               stage_r[gi] <= stage_r[gi-1];
            end
         end
      end
   endgenerate

   assign last_status = stage_r[DEPTH-1];

   restore_load_a: assert property (
      @(posedge core_clk) disable iff (!nrst)
      load_en |=> stage_r[0] == $past(load_status))
      else $error("first stage missed restored status");

   hold_idle_a: assert property (
      @(posedge core_clk) disable iff (!nrst)
      !advance |=> $stable(last_status))
      else $error("last stage moved without an operation");

endmodule // fsc_stat_pipe

// ### fsc_pipe_model.sv
`timescale 1ns/10ps
module fsc_pipe_model (
   // clock
   input  wire logic        core_clk,
   // adder pipe
   output logic             add_advance,
   output logic [3:0]       add_stat,
   output logic [10:0]      add_exp,
   output logic             add_report,
   // multiplier pipe
   output logic             mul_advance,
   output logic [3:0]       mul_stat,
   output logic             mul_report,
   // reported operation
   output logic             op_scalar,
   output logic [4:0]       dest_idx,
   // last-stage precision, add mul gfx
   output logic [1:0]       load_size,
   output logic [2:0]       prec
);
   initial begin
      add_advance = 1'b0;
      add_stat    = 4'h0;
      add_exp     = 11'h000;
      add_report  = 1'b0;
      mul_advance = 1'b0;
      mul_stat    = 4'h0;
      mul_report  = 1'b0;
      op_scalar   = 1'b0;
      dest_idx    = 5'h00;
      load_size   = 2'h0;
      prec        = 3'h0;
   end

   // one adder operation, status inverted after the advance
   task automatic add_op(input logic [3:0] st, input logic [10:0] e);
      @(posedge core_clk);
      add_advance <= 1'b1;
      add_stat    <= st;
      add_exp     <= e;
      @(posedge core_clk);
      add_advance <= 1'b0;
      add_stat    <= ~st;
      add_exp     <= ~e;
   endtask

   task automatic mul_op(input logic [3:0] st);
      @(posedge core_clk);
      mul_advance <= 1'b1;
      mul_stat    <= st;
      @(posedge core_clk);
      mul_advance <= 1'b0;
      mul_stat    <= ~st;
   endtask

   // exception report of the last stage
   task automatic report(input logic a, input logic m, input logic sc,
                         input logic [4:0] idx);
      @(posedge core_clk);
      add_report <= a;
      mul_report <= m;
      op_scalar  <= sc;
      dest_idx   <= idx;
      @(posedge core_clk);
      add_report <= 1'b0;
      mul_report <= 1'b0;
      op_scalar  <= 1'b0;
      dest_idx   <= ~idx;
   endtask

   // last-stage precision levels
   task automatic set_prec(input logic [1:0] sz, input logic [2:0] p);
      @(posedge core_clk);
      load_size <= sz;
      prec      <= p;
      @(posedge core_clk);
   endtask
endmodule // fsc_pipe_model

// ### tb_fsc_status_reg.sv
`timescale 1ns/10ps
module tb_fsc_status_reg;
   localparam int D = fsc_pkg::ADD_DEPTH;
   logic                core_clk, nrst, ctl_store_en, src_check, src_invalid;
   logic [31:0]         ctl_store_data, status_word;
   logic                a_adv, a_rep, m_adv, m_rep, sc, flush_zero;
   logic                result_trap, source_trap;
   logic [3:0]          a_st, m_st;
   logic [10:0]         a_exp;
   logic [4:0]          idx;
   logic [1:0]          lsz;
   logic [2:0]          prec;
   fsc_pkg::fsc_round_t round_mode;
   int                  err_count, checked, cycles, k;

   fsc_pipe_model i_pipe (.core_clk(core_clk), .add_advance(a_adv),
      .add_stat(a_st), .add_exp(a_exp), .add_report(a_rep),
      .mul_advance(m_adv), .mul_stat(m_st), .mul_report(m_rep),
      .op_scalar(sc), .dest_idx(idx), .load_size(lsz), .prec(prec));

   fsc_status_reg i_dut (.core_clk(core_clk), .nrst(nrst),
      .ctl_store_en(ctl_store_en), .ctl_store_data(ctl_store_data),
      .status_word(status_word), .add_advance(a_adv),
      .add_round_up(a_st[3]), .add_inexact(a_st[2]),
      .add_overflow(a_st[1]), .add_underflow(a_st[0]), .add_exp(a_exp),
      .add_report(a_rep), .add_scalar(sc), .add_dest_idx(idx),
      .mul_advance(m_adv), .mul_round_up(m_st[3]), .mul_inexact(m_st[2]),
      .mul_overflow(m_st[1]), .mul_underflow(m_st[0]),
      .mul_report(m_rep), .mul_scalar(sc), .mul_dest_idx(idx),
      .load_size(lsz), .gfx_double(prec[0]), .mul_double(prec[1]),
      .add_double(prec[2]), .src_check(src_check),
      .src_invalid(src_invalid), .round_mode(round_mode),
      .flush_zero(flush_zero), .result_trap(result_trap),
      .source_trap(source_trap));

   initial core_clk = 1'b0;
   always #50 core_clk = ~core_clk;

   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         err_count++;
         $display("mismatch at %0t: run too long", $time);
         stop_test();
      end
   end

   task automatic cmp_bit(input logic got, input logic exp, input string m);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: %s got %b", $time, m, got);
      end
   endtask

   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp,
                           input string m);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic store(input logic [31:0] d);
      @(posedge core_clk);
      ctl_store_en   <= 1'b1;
      ctl_store_data <= d;
      @(posedge core_clk);
      ctl_store_en   <= 1'b0;
      ctl_store_data <= ~d;
      #1;
   endtask

   task automatic push_zeros;
      repeat (D - 1) i_pipe.add_op(4'h0, 11'h000);
      repeat (fsc_pkg::MUL_DEPTH - 1) i_pipe.mul_op(4'h0);
      #1;
   endtask

   // one adder op reaches the last stage, then is reported
   task automatic run_trap(input logic [31:0] c, input logic [3:0] st,
                           input logic exp);
      store(c);
      i_pipe.add_op(st, 11'h000);
      repeat (D - 1) i_pipe.add_op(4'h0, 11'h000);
      i_pipe.report(1'b1, 1'b0, 1'b0, 5'h00);
      #1;
      cmp_bit(result_trap, exp, "result trap");
      @(posedge core_clk);
      #1;
      cmp_bit(result_trap, 1'b0, "trap width");
   endtask

   task automatic src_op(input logic inv, input logic exp);
      @(posedge core_clk);
      src_check   <= 1'b1;
      src_invalid <= inv;
      @(posedge core_clk);
      src_check   <= 1'b0;
      src_invalid <= ~inv;
      #1;
      cmp_bit(source_trap, exp, "source trap");
      cmp_bit(status_word[8], inv, "operand flag");
   endtask

   initial begin
      nrst = 1'b0;
      ctl_store_en = 1'b0;
      ctl_store_data = 32'h00000000;
      src_check = 1'b0;
      src_invalid = 1'b0;
      err_count = 0;
      checked = 0;
      cycles = 0;
      repeat (5) @(posedge core_clk);
      nrst <= 1'b1;
      #1;
      cmp_word(status_word, 32'h00000000, "reset word");
      cmp_bit(result_trap | source_trap, 1'b0, "reset traps");
      $display("test reset done");

      store(32'hFFFFFFEF);
      cmp_word(status_word, 32'h003E01AF, "direct fields");
      cmp_bit(flush_zero, 1'b1, "flush control");
      for (k = 0; k < 4; k++) begin
         store(32'(k) << 2);
         cmp_word({30'h0, round_mode}, 32'(k), "round mode");
      end
      $display("test store done");

      store(32'h01408810);
      cmp_word(status_word, 32'h00000000, "update not kept");
      push_zeros();
      cmp_word(status_word, 32'h01408880, "restored status");
      push_zeros();
      cmp_word(status_word, 32'h00000080, "sticky kept");
      store(32'h00000000);
      cmp_word(status_word, 32'h00000000, "sticky cleared");
      $display("test restore done");

      store(32'h00000020);
      i_pipe.add_op(4'hA, 11'h7FF);
      repeat (D - 1) i_pipe.add_op(4'h0, 11'h000);
      #1;
      cmp_word(status_word, 32'h01C14020, "sum status");
      i_pipe.report(1'b1, 1'b0, 1'b1, 5'h13);
      #1;
      cmp_bit(result_trap, 1'b1, "scalar trap");
      cmp_word(status_word, 32'h01E74020, "dest index");
      i_pipe.mul_op(4'h2);
      repeat (fsc_pkg::MUL_DEPTH - 1) i_pipe.mul_op(4'h0);
      i_pipe.report(1'b0, 1'b1, 1'b0, 5'h00);
      #1;
      cmp_bit(result_trap, 1'b1, "product trap");
      $display("test pipeline done");

      run_trap(32'h00000020, 4'h2, 1'b1);
      run_trap(32'h00000000, 4'h2, 1'b0);
      run_trap(32'h00000020, 4'h1, 1'b1);
      run_trap(32'h00000021, 4'h1, 1'b0);
      run_trap(32'h00000020, 4'h4, 1'b0);
      run_trap(32'h00000022, 4'h4, 1'b1);
      run_trap(32'h00000002, 4'h4, 1'b0);
      $display("test traps done");

      store(32'h00000020);
      src_op(1'b1, 1'b1);
      src_op(1'b0, 1'b0);
      store(32'h00000000);
      src_op(1'b1, 1'b0);
      $display("test source done");

      for (k = 1; k < 4; k++) begin
         i_pipe.set_prec(k[1:0], 3'(k + 3));
         #1;
         cmp_word(status_word & 32'h3E000000,
                  {2'b00, k[1], 3'(k + 3), k[0], 25'h0}, "precision");
         store(32'hFFFFFFEF);
         cmp_word(status_word & 32'h3E000000,
                  {2'b00, k[1], 3'(k + 3), k[0], 25'h0}, "precision hold");
      end
      $display("test precision done");
      stop_test();
   end
endmodule // tb_fsc_status_reg
